// File: uep_pkg.sv
// Constants, types and helpers shared by the control-endpoint request block.
// Contract
// - After reset completes the device detaches and waits for the master's enumerate command.
// - While reset is held the device cannot detach, so it stays attached.
// - Endpoint 4, 6, 8 length high bytes read back a wrong low nibble.
// - A device status answer always reports the self-powered bit as zero.
// - A SET_INTERFACE request raises the setup notification to the master.
// - Non-standard no-data requests are acknowledged only after the master writes zero count.
// - SET_INTERFACE status stage is acknowledged by the device itself.
// - Each setup packet overwrites the setup register; the master must read it first.
package uep_pkg;

    localparam int          DATA_W          = 32;
    localparam int          IDX_W           = 8;
    localparam int          BYTE_W          = 8;
    localparam int          SETUP_BYTES     = 8;
    localparam int          PTR_W           = 3;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0]  IDX_EP4_LEN_HI  = 8'h0C;
    localparam logic [7:0]  IDX_EP6_LEN_HI  = 8'h0E;
    localparam logic [7:0]  IDX_EP8_LEN_HI  = 8'h10;
    localparam logic [7:0]  IDX_SETUP       = 8'h32;
    localparam logic [7:0]  IDX_EP0_COUNT   = 8'h33;
    localparam logic [7:0]  IDX_CTRL        = 8'h3C;
    localparam logic [7:0]  IDX_STATUS      = 8'h3D;
    localparam int          ADDR_IDX_LSB    = 2;

    localparam logic [7:0]  LEN_HI_RESET    = 8'h00;
    localparam logic [3:0]  LOW_NIBBLE_MASK = 4'hF;

    // Control register fields.
    localparam int          CTRL_ENUM_BIT   = 0;
    localparam int          CTRL_SELFPWR    = 1;
    localparam int          CTRL_RWU_BIT    = 2;
    localparam logic [2:0]  CTRL_RESET      = 3'h0;

    // Status register fields.
    localparam int          STAT_ATTACHED   = 0;
    localparam int          STAT_WAIT_CNT   = 1;
    localparam int          STAT_ACK_READY  = 2;
    localparam int          STAT_UNREAD     = 3;
    localparam int          STAT_OVERRUN    = 4;

    // Setup packet request fields.
    localparam logic [7:0]  REQ_SET_IFACE   = 8'h0B;
    localparam logic [7:0]  TYPE_SET_IFACE  = 8'h01;
    localparam logic [1:0]  TYPE_STANDARD   = 2'h0;

    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [15:0] DEV_STATUS_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        LINK_RESET    = 3'b001,
        LINK_DETACHED = 3'b010,
        LINK_ATTACHED = 3'b100
    } uep_link_t;

    typedef enum logic [2:0] {
        HS_IDLE  = 3'b001,
        HS_WAIT  = 3'b010,
        HS_READY = 3'b100
    } uep_hs_t;

    function automatic logic is_set_interface(input logic [63:0] pkt);
        is_set_interface = (pkt[7:0] == TYPE_SET_IFACE) && (pkt[15:8] == REQ_SET_IFACE);
    endfunction : is_set_interface

    function automatic logic is_nonstd_nodata(input logic [63:0] pkt);
        is_nonstd_nodata = (pkt[6:5] != TYPE_STANDARD) && (pkt[63:48] == 16'h0000);
    endfunction : is_nonstd_nodata

endpackage : uep_pkg

// File: uep_regbus_if.sv
// Internal register access carrier between the bus slave and the core.
`timescale 1ns/100ps
interface uep_regbus_if;
    import uep_pkg::*;

    logic                rd;
    logic                wr;
    logic [IDX_W-1:0]    rd_idx;
    logic [IDX_W-1:0]    wr_idx;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   rdata;

    modport slave_side
    (
        output rd,
        output wr,
        output rd_idx,
        output wr_idx,
        output wdata,
        input  rdata
    );

    modport core_side
    (
        input  rd,
        input  wr,
        input  rd_idx,
        input  wr_idx,
        input  wdata,
        output rdata
    );
endinterface : uep_regbus_if

// File: uep_setup_mem.sv
// Eight-byte setup packet store with a registered byte read port.
`timescale 1ns/100ps
module uep_setup_mem
(
    input  wire logic                                  clk,
    input  wire logic                                  wr_en,
    input  wire logic [63:0]                           wr_pkt,
    input  wire logic [uep_pkg::PTR_W-1:0]             rd_ptr,
    output logic      [uep_pkg::BYTE_W-1:0]            rd_byte
);
    import uep_pkg::*;

    logic [BYTE_W-1:0] mem [SETUP_BYTES];

    // A new packet replaces all eight bytes at once.
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            for (int i = 0; i < SETUP_BYTES; i++)
            begin
                mem[i] <= wr_pkt[i*BYTE_W +: BYTE_W];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        rd_byte <= mem[rd_ptr];
    end
endmodule : uep_setup_mem

// File: uep_ahb_slave.sv
// AHB-Lite slave front end with zero wait states and registered read data.
`timescale 1ns/100ps
module uep_ahb_slave
(
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          hsel,
    input  wire logic [uep_pkg::DATA_W-1:0]    haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic                          hready,
    input  wire logic [uep_pkg::DATA_W-1:0]    hwdata,
    output logic      [uep_pkg::DATA_W-1:0]    hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    uep_regbus_if.slave_side                   bus
);
    import uep_pkg::*;

    logic              wr_pend_r;
    logic [IDX_W-1:0]  wr_idx_r;

    wire addr_phase = hsel && hready && htrans[1];
    wire take_read  = addr_phase && !hwrite;
    wire take_write = addr_phase && hwrite;

    assign bus.rd     = take_read;
    assign bus.rd_idx = haddr[ADDR_IDX_LSB +: IDX_W];
    assign bus.wr     = wr_pend_r;
    assign bus.wr_idx = wr_idx_r;
    assign bus.wdata  = hwdata;

    // Read data is latched at the address phase so it stands through the data phase.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end
        else
        begin
            wr_pend_r <= take_write;
            wr_idx_r  <= take_write ? haddr[ADDR_IDX_LSB +: IDX_W] : wr_idx_r;
            hrdata    <= take_read ? bus.rdata : hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
endmodule : uep_ahb_slave

// File: uep_ep0_quirks.sv
// Control endpoint request handling, attach control and register readback.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps
module uep_ep0_quirks
(
    input  wire logic                          CORE_CLK,
    input  wire logic                          NRST,
    input  wire logic                          HSEL,
    input  wire logic [uep_pkg::DATA_W-1:0]    HADDR,
    input  wire logic [1:0]                    HTRANS,
    input  wire logic                          HWRITE,
    input  wire logic [2:0]                    HSIZE,
    input  wire logic                          HREADY,
    input  wire logic [uep_pkg::DATA_W-1:0]    HWDATA,
    output logic      [uep_pkg::DATA_W-1:0]    HRDATA,
    output logic                               HREADYOUT,
    output logic                               HRESP,
    input  wire logic                          SETUP_VALID,
    input  wire logic [63:0]                   SETUP_DATA,
    input  wire logic                          STATUS_REQ,
    output logic                               STATUS_ACK,
    output logic                               STATUS_NAK,
    output logic                               SETUP_EVT,
    output logic                               USB_ATTACH,
    output logic      [15:0]                   DEV_STATUS,
    output logic      [7:0]                    EP4_LEN_HIGH,
    output logic      [7:0]                    EP6_LEN_HIGH,
    output logic      [7:0]                    EP8_LEN_HIGH
);
    import uep_pkg::*;

    uep_regbus_if regbus ();

    // Register state.
    logic [7:0]        ep4_packet_length_high_r;
    logic [7:0]        ep6_packet_length_high_r;
    logic [7:0]        ep8_packet_length_high_r;
    logic [2:0]        ctrl_r;
    logic [PTR_W-1:0]  setup_ptr_r;
    logic [PTR_W-1:0]  setup_ptr_nxt;
    logic              unread_r;
    logic              unread_nxt;
    logic              overrun_r;
    logic              overrun_nxt;
    logic [BYTE_W-1:0] setup_byte;

    uep_link_t         link_r;
    uep_link_t         link_nxt;
    uep_hs_t           hs_r;
    uep_hs_t           hs_nxt;

    // Bus slave and setup packet store.
    uep_ahb_slave u_slave
    (
        .clk       (CORE_CLK),
        .rst_n     (NRST),
        .hsel      (HSEL),
        .haddr     (HADDR),
        .htrans    (HTRANS),
        .hwrite    (HWRITE),
        .hready    (HREADY),
        .hwdata    (HWDATA),
        .hrdata    (HRDATA),
        .hreadyout (HREADYOUT),
        .hresp     (HRESP),
        .bus       (regbus.slave_side)
    );

    uep_setup_mem u_setup
    (
        .clk     (CORE_CLK),
        .wr_en   (SETUP_VALID),
        .wr_pkt  (SETUP_DATA),
        .rd_ptr  (setup_ptr_r),
        .rd_byte (setup_byte)
    );

    // Write decode and setup read decode.
    wire wr_ep4    = regbus.wr && (regbus.wr_idx == IDX_EP4_LEN_HI);
    wire wr_ep6    = regbus.wr && (regbus.wr_idx == IDX_EP6_LEN_HI);
    wire wr_ep8    = regbus.wr && (regbus.wr_idx == IDX_EP8_LEN_HI);
    wire wr_ctrl   = regbus.wr && (regbus.wr_idx == IDX_CTRL);
    wire wr_status = regbus.wr && (regbus.wr_idx == IDX_STATUS);
    wire wr_count  = regbus.wr && (regbus.wr_idx == IDX_EP0_COUNT);
    wire wr_zero   = wr_count && (regbus.wdata[7:0] == 8'h00);
    wire rd_setup  = regbus.rd && (regbus.rd_idx == IDX_SETUP);

    // Setup packet classification.
    wire pkt_set_iface = is_set_interface(SETUP_DATA);
    wire pkt_wait_cnt  = is_nonstd_nodata(SETUP_DATA);

    // Stored length bytes drive the endpoints; the low nibble reads back corrupted.
    wire [7:0] ep4_rd = {ep4_packet_length_high_r[7:4],
                         ep4_packet_length_high_r[3:0] ^ LOW_NIBBLE_MASK};
    wire [7:0] ep6_rd = {ep6_packet_length_high_r[7:4],
                         ep6_packet_length_high_r[3:0] ^ LOW_NIBBLE_MASK};
    wire [7:0] ep8_rd = {ep8_packet_length_high_r[7:4],
                         ep8_packet_length_high_r[3:0] ^ LOW_NIBBLE_MASK};

    wire [7:0] status_rd;
    assign status_rd[STAT_ATTACHED]  = (link_r == LINK_ATTACHED);
    assign status_rd[STAT_WAIT_CNT]  = (hs_r == HS_WAIT);
    assign status_rd[STAT_ACK_READY] = (hs_r == HS_READY);
    assign status_rd[STAT_UNREAD]    = unread_r;
    assign status_rd[STAT_OVERRUN]   = overrun_r;
    assign status_rd[7:5]            = 3'h0;

    // Read multiplexer; unmapped indices read as zero.
    logic [7:0] rd_byte_sel;
    always_comb
    begin
        unique case (regbus.rd_idx)
            IDX_EP4_LEN_HI: rd_byte_sel = ep4_rd;
            IDX_EP6_LEN_HI: rd_byte_sel = ep6_rd;
            IDX_EP8_LEN_HI: rd_byte_sel = ep8_rd;
            IDX_SETUP:      rd_byte_sel = setup_byte;
            IDX_CTRL:       rd_byte_sel = {5'h00, ctrl_r};
            IDX_STATUS:     rd_byte_sel = status_rd;
            default:        rd_byte_sel = 8'h00;
        endcase
    end
    assign regbus.rdata = {24'h00_0000, rd_byte_sel};

    // Setup read pointer walks the eight bytes; a new packet restarts it.
    always_comb
    begin
        setup_ptr_nxt = setup_ptr_r;
        if (SETUP_VALID)
        begin
            setup_ptr_nxt = '0;
        end
        else if (rd_setup)
        begin
            setup_ptr_nxt = setup_ptr_r + 3'd1;
        end
    end

    // A packet that lands on an unread one is flagged; a new event beats the clear.
    always_comb
    begin
        unread_nxt  = unread_r;
        overrun_nxt = overrun_r;
        if (rd_setup)
        begin
            unread_nxt = 1'b0;
        end
        if (wr_status && regbus.wdata[STAT_OVERRUN])
        begin
            overrun_nxt = 1'b0;
        end
        if (SETUP_VALID)
        begin
            unread_nxt  = 1'b1;
            overrun_nxt = overrun_r || unread_r;
        end
    end

    // Attach sequencing: attached while held in reset, detached after release.
    always_comb
    begin
        link_nxt = link_r;
        unique case (link_r)
            LINK_RESET:
            begin
                link_nxt = LINK_DETACHED;
            end
            LINK_DETACHED:
            begin
                if (wr_ctrl && regbus.wdata[CTRL_ENUM_BIT])
                begin
                    link_nxt = LINK_ATTACHED;
                end
            end
            LINK_ATTACHED:
            begin
                if (wr_ctrl && !regbus.wdata[CTRL_ENUM_BIT])
                begin
                    link_nxt = LINK_DETACHED;
                end
            end
        endcase
    end

    // Status stage handshake; a new setup packet always restarts it.
    always_comb
    begin
        hs_nxt = hs_r;
        if (SETUP_VALID)
        begin
            if (pkt_set_iface)
            begin
                hs_nxt = HS_READY;
            end
            else if (pkt_wait_cnt)
            begin
                hs_nxt = HS_WAIT;
            end
            else
            begin
                hs_nxt = HS_READY;
            end
        end
        else
        begin
            unique case (hs_r)
                HS_IDLE:
                begin
                    hs_nxt = HS_IDLE;
                end
                HS_WAIT:
                begin
                    if (wr_zero)
                    begin
                        hs_nxt = HS_READY;
                    end
                end
                HS_READY:
                begin
                    if (STATUS_REQ)
                    begin
                        hs_nxt = HS_IDLE;
                    end
                end
            endcase
        end
    end

    // Length registers and control register.
    always_ff @(posedge CORE_CLK)
    begin
        if (!NRST)
        begin
            ep4_packet_length_high_r <= LEN_HI_RESET;
            ep6_packet_length_high_r <= LEN_HI_RESET;
            ep8_packet_length_high_r <= LEN_HI_RESET;
            ctrl_r                   <= CTRL_RESET;
        end
        else
        begin
            ep4_packet_length_high_r <= wr_ep4 ? regbus.wdata[7:0] : ep4_packet_length_high_r;
            ep6_packet_length_high_r <= wr_ep6 ? regbus.wdata[7:0] : ep6_packet_length_high_r;
            ep8_packet_length_high_r <= wr_ep8 ? regbus.wdata[7:0] : ep8_packet_length_high_r;
            ctrl_r                   <= wr_ctrl ? regbus.wdata[2:0] : ctrl_r;
        end
    end

    // Sequencing state.
    always_ff @(posedge CORE_CLK)
    begin
        if (!NRST)
        begin
            link_r      <= LINK_RESET;
            hs_r        <= HS_IDLE;
            setup_ptr_r <= '0;
            unread_r    <= 1'b0;
            overrun_r   <= 1'b0;
        end
        else
        begin
            link_r      <= link_nxt;
            hs_r        <= hs_nxt;
            setup_ptr_r <= setup_ptr_nxt;
            unread_r    <= unread_nxt;
            overrun_r   <= overrun_nxt;
        end
    end

    // Registered outputs toward the link and the endpoints.
    always_ff @(posedge CORE_CLK)
    begin
        if (!NRST)
        begin
            USB_ATTACH   <= 1'b1;
            SETUP_EVT    <= 1'b0;
            STATUS_ACK   <= 1'b0;
            STATUS_NAK   <= 1'b0;
            DEV_STATUS   <= DEV_STATUS_ZERO;
            EP4_LEN_HIGH <= LEN_HI_RESET;
            EP6_LEN_HIGH <= LEN_HI_RESET;
            EP8_LEN_HIGH <= LEN_HI_RESET;
        end
        else
        begin
            USB_ATTACH   <= (link_nxt == LINK_ATTACHED);
            SETUP_EVT    <= SETUP_VALID;
            STATUS_ACK   <= STATUS_REQ && !SETUP_VALID && (hs_r == HS_READY);
            STATUS_NAK   <= STATUS_REQ && !SETUP_VALID && (hs_r != HS_READY);
            DEV_STATUS   <= {14'h0000, ctrl_r[CTRL_RWU_BIT], 1'b0};
            EP4_LEN_HIGH <= ep4_packet_length_high_r;
            EP6_LEN_HIGH <= ep6_packet_length_high_r;
            EP8_LEN_HIGH <= ep8_packet_length_high_r;
        end
    end
endmodule : uep_ep0_quirks

// File: uep_ep0_monitor.sv
// Checker of the control endpoint request block, bound to its top-level ports.
`timescale 1ns/100ps
module uep_ep0_monitor
(
    input wire logic        CORE_CLK,
    input wire logic        NRST,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic [31:0] HWDATA,
    input wire logic        SETUP_VALID,
    input wire logic [63:0] SETUP_DATA,
    input wire logic        STATUS_REQ,
    input wire logic        STATUS_ACK,
    input wire logic        STATUS_NAK,
    input wire logic        SETUP_EVT,
    input wire logic        USB_ATTACH,
    input wire logic [15:0] DEV_STATUS,
    input wire logic [7:0]  EP4_LEN_HIGH
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);

    logic armed = 1'h0;
    wire  iface  = SETUP_VALID && SETUP_DATA[15:0] == 16'h0B01;
    wire  nonstd = SETUP_VALID && SETUP_DATA[6:5] != 2'h0 && SETUP_DATA[63:48] == 16'h0000;
    wire  ep4_wr = HSEL && HREADY && HTRANS[1] && HWRITE && HADDR[9:2] == 8'h0C;

    // Marks that one edge has passed, so the history of the reset line is known.
    always_ff @(posedge CORE_CLK)
        armed <= 1'h1;

    a_detach_release: assert property (!$past(NRST) && NRST |=> !USB_ATTACH)
        else $error("attach line not dropped after reset");
    a_attach_reset: assert property (disable iff (1'h0)
        armed && !NRST && !$past(NRST) |-> USB_ATTACH)
        else $error("attach line low during reset");
    a_selfpwr_zero: assert property (!DEV_STATUS[0])
        else $error("self powered bit reported");
    a_setup_notify: assert property (SETUP_VALID ##1 !SETUP_VALID |-> SETUP_EVT ##1 !SETUP_EVT)
        else $error("setup notification not a single pulse");
    a_nonstd_wait: assert property (nonstd ##1 STATUS_REQ && !SETUP_VALID |=> STATUS_NAK)
        else $error("no-data request answered before zero count");
    a_ack_then_nak: assert property (STATUS_ACK ##1 STATUS_REQ && !SETUP_VALID |=> STATUS_NAK)
        else $error("second status stage not refused");
    a_iface_selfack: assert property (iface ##1 STATUS_REQ && !SETUP_VALID |=> STATUS_ACK)
        else $error("interface request not acknowledged");
    a_overlap_quiet: assert property (SETUP_VALID && STATUS_REQ |=> !STATUS_ACK && !STATUS_NAK)
        else $error("status answered in setup cycle");
    a_len_written: assert property (ep4_wr ##2 1'h1 |=> EP4_LEN_HIGH == $past(HWDATA[7:0], 2))
        else $error("length output differs from written value");

    c_iface: cover property (iface ##1 STATUS_REQ);
    c_nonstd: cover property (nonstd ##1 STATUS_REQ);
    c_ack: cover property (STATUS_ACK);
endmodule : uep_ep0_monitor

bind uep_ep0_quirks uep_ep0_monitor mon_u
(
    .CORE_CLK(CORE_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA), .SETUP_VALID(SETUP_VALID),
    .SETUP_DATA(SETUP_DATA), .STATUS_REQ(STATUS_REQ), .STATUS_ACK(STATUS_ACK),
    .STATUS_NAK(STATUS_NAK), .SETUP_EVT(SETUP_EVT), .USB_ATTACH(USB_ATTACH),
    .DEV_STATUS(DEV_STATUS), .EP4_LEN_HIGH(EP4_LEN_HIGH)
);

// File: uep_host_model.sv
// Behavioural USB host that sends setup packets and asks for status stages.
`timescale 1ns/100ps
module uep_host_model
(
    input  wire logic   clk,
    output logic        setup_valid,
    output logic [63:0] setup_data,
    output logic        status_req,
    input  wire logic   status_ack,
    input  wire logic   status_nak
);
    initial
    begin
        setup_valid = 1'h0;
        setup_data  = 64'h0000_0000_0000_0000;
        status_req  = 1'h0;
    end

    // Once taken, the data lines show the inverse of the packet.
    task automatic send_setup(input logic [63:0] pkt, input logic req);
        setup_valid <= 1'h1;
        setup_data  <= pkt;
        if (req)
            status_req <= 1'h1;
        @(posedge clk);
        setup_valid <= 1'h0;
        setup_data  <= ~pkt;
        if (req)
            status_req <= 1'h0;
    endtask : send_setup

    task automatic status_stage(output logic ack, output logic nak);
        status_req <= 1'h1;
        @(posedge clk);
        status_req <= 1'h0;
        @(negedge clk);
        ack = status_ack;
        nak = status_nak;
        @(posedge clk);
    endtask : status_stage
endmodule : uep_host_model

// File: uep_ep0_quirks_bench.sv
// Self-checking bench of the control endpoint request block.
`timescale 1ns/100ps
module uep_ep0_quirks_bench;
    import uep_pkg::*;

    logic        core_clk = 1'h0;
    logic        nrst     = 1'h0;
    logic        hsel     = 1'h0;
    logic        hwrite   = 1'h0;
    logic [1:0]  htrans   = 2'h0;
    logic [31:0] haddr    = 32'h0000_0000;
    logic [31:0] hwdata   = 32'h0000_0000;
    logic [31:0] hrdata, rd, r;
    logic        hreadyout, hresp, setup_valid, status_req, status_ack, status_nak;
    logic        setup_evt, usb_attach, ack, nak;
    logic [63:0] setup_data, pkt;
    logic [15:0] dev_status;
    logic [7:0]  ep4_len, ep6_len, ep8_len;
    logic [7:0]  len_copy [3];
    logic [7:0]  len_idx [3] = '{IDX_EP4_LEN_HI, IDX_EP6_LEN_HI, IDX_EP8_LEN_HI};
    logic [7:0]  setup_q [$];
    logic [31:0] rng = 32'h0000_7DE0;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          evt_cnt = 0;

    uep_ep0_quirks dut_u
    (
        .CORE_CLK(core_clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .SETUP_VALID(setup_valid),
        .SETUP_DATA(setup_data), .STATUS_REQ(status_req), .STATUS_ACK(status_ack),
        .STATUS_NAK(status_nak), .SETUP_EVT(setup_evt), .USB_ATTACH(usb_attach),
        .DEV_STATUS(dev_status), .EP4_LEN_HIGH(ep4_len), .EP6_LEN_HIGH(ep6_len),
        .EP8_LEN_HIGH(ep8_len)
    );

    uep_host_model host_u
    (
        .clk(core_clk), .setup_valid(setup_valid), .setup_data(setup_data),
        .status_req(status_req), .status_ack(status_ack), .status_nak(status_nak)
    );

    always #20 core_clk = ~core_clk;

    always @(negedge core_clk)
        if (setup_evt === 1'h1)
            evt_cnt++;

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    function automatic logic [31:0] next_rand();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : next_rand

    // The low nibble of these length bytes reads back inverted.
    function automatic logic [31:0] len_readback(input logic [7:0] v);
        return {24'h00_0000, v[7:4], ~v[3:0]};
    endfunction : len_readback

    task automatic complete_run();
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_word({31'h0000_0000, got}, {31'h0000_0000, exp}, what);
    endtask : chk_bit

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdv);
        hsel   <= 1'h1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr  <= {22'h00_0000, idx, 2'h0};
        @(posedge core_clk);
        while (hreadyout !== 1'h1)
            @(posedge core_clk);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge core_clk);
        while (hreadyout !== 1'h1)
            @(posedge core_clk);
        rdv = hrdata;
        chk_bit(hresp, 1'h0, "bus response");
    endtask : bus

    task automatic settle();
        @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle

    task automatic load_setup(input logic [63:0] p);
        setup_q = {};
        for (int j = 0; j < 8; j++)
            setup_q.push_back(p[8*j +: 8]);
    endtask : load_setup

    task automatic read_setup();
        repeat (8)
        begin
            bus(1'h0, IDX_SETUP, 32'h0000_0000, rd);
            chk_word(rd, {24'h00_0000, setup_q.pop_front()}, "setup byte");
        end
    endtask : read_setup

    task automatic do_reset();
        nrst <= 1'h0;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        chk_bit(usb_attach, 1'h1, "attach in reset");
        @(posedge core_clk);
        nrst <= 1'h1;
        settle();
        chk_bit(usb_attach, 1'h0, "detach after reset");
        repeat (4) @(negedge core_clk);
        chk_bit(usb_attach, 1'h0, "stays detached");
        len_copy = '{LEN_HI_RESET, LEN_HI_RESET, LEN_HI_RESET};
        @(posedge core_clk);
    endtask : do_reset

    initial
    begin
        do_reset();
        bus(1'h1, IDX_CTRL, 32'h0000_0007, rd);
        settle();
        chk_bit(usb_attach, 1'h1, "enumerate");
        chk_word({16'h0000, dev_status}, 32'h0000_0002, "device status");
        @(posedge core_clk);
        bus(1'h1, IDX_CTRL, 32'h0000_0000, rd);
        settle();
        chk_word({15'h0000, usb_attach, dev_status}, 32'h0000_0000, "detach");
        @(posedge core_clk);
        foreach (len_copy[i])
        begin
            r = next_rand();
            len_copy[i] = r[7:0];
            bus(1'h1, len_idx[i], r, rd);
        end
        foreach (len_copy[i])
        begin
            bus(1'h0, len_idx[i], 32'h0000_0000, rd);
            chk_word(rd, len_readback(len_copy[i]), "length readback");
        end
        chk_word({8'h00, ep4_len, ep6_len, ep8_len},
                 {8'h00, len_copy[0], len_copy[1], len_copy[2]}, "length outputs");
        bus(1'h1, 8'h05, 32'hFFFF_FFFF, rd);
        bus(1'h0, 8'h05, 32'h0000_0000, rd);
        chk_word(rd, 32'h0000_0000, "unmapped");
        for (int k = 0; k < 3; k++)
        begin
            r = next_rand();
            pkt = (k == 0) ? {16'h0000, r, 16'h0B01} :
                  (k == 1) ? {16'h0012, r, 16'h0680} : {16'h0000, r, 16'h5A41};
            load_setup(pkt);
            host_u.send_setup(pkt, 1'h0);
            host_u.status_stage(ack, nak);
            chk_word({30'h0000_0000, ack, nak}, (k == 2) ? 32'h0000_0001 : 32'h0000_0002,
                     "first status");
            chk_word(evt_cnt, k + 1, "setup events");
            if (k == 2)
            begin
                bus(1'h1, IDX_EP0_COUNT, 32'h0000_0000, rd);
                host_u.status_stage(ack, nak);
                chk_bit(ack, 1'h1, "released ack");
            end
            host_u.status_stage(ack, nak);
            chk_bit(nak, 1'h1, "repeat nak");
            read_setup();
        end
        host_u.send_setup({16'h0000, next_rand(), 16'h0B01}, 1'h0);
        @(posedge core_clk);
        pkt = {16'h0000, next_rand(), 16'h0B01};
        load_setup(pkt);
        host_u.send_setup(pkt, 1'h1);
        @(negedge core_clk);
        chk_word({30'h0000_0000, status_ack, status_nak}, 32'h0000_0000, "overlap");
        @(posedge core_clk);
        bus(1'h0, IDX_STATUS, 32'h0000_0000, rd);
        chk_bit(rd[STAT_OVERRUN], 1'h1, "overrun flag");
        read_setup();
        do_reset();
        bus(1'h0, IDX_EP4_LEN_HI, 32'h0000_0000, rd);
        chk_word(rd, len_readback(len_copy[0]), "length after reset");
        complete_run();
    end
endmodule : uep_ep0_quirks_bench
